// file: hw/srsc_pkg.sv
// types for the start-up reset state control block
package srsc_pkg;
    // release sequence, gray coded along the usual path
    typedef enum logic [1:0] {
        SRSC_ST_COLD  = 2'b00,
        SRSC_ST_SYS   = 2'b01,
        SRSC_ST_RUN   = 2'b11
    } srsc_state_t;
endpackage

// file: hw/srsc_ram.sv
// data ram with no reset and a registered read port
`timescale 1ns/100ps
module srsc_ram #(
    parameter int WORDS = 512,
    parameter int AW    = 9
) (
    input  wire logic          mclk,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);
    // refuse a depth that the address cannot reach
    if (WORDS > (1 << AW)) begin : g_bad_depth
        $error("srsc_ram: depth exceeds address range");
    end
    logic [7:0] mem [WORDS];  // contents undefined at start-up
    // no reset input at all: nothing may ever clear the array
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// file: hw/srsc_regs.svh
// constants and behaviour summary for the start-up reset state control block
// Behaviour
// - power-on reset forces every state bit except the data ram to reset
// - after power-on: rc oscillator on, crystal off
// - power-on reset restarts processor fetch at zero
// - port-a sleep wake keeps cold-governed bits unchanged
// - system reset clears system bits, port-config if enabled
// - system reset keeps clock setup except processor clock
// - data ram is never cleared by reset
// - cold reset asserted whenever power-on reset active
// - system reset asserted on cold or enabled sources
// - port-config reset only with system reset and enable, or with cold reset
`ifndef SRSC_REGS_SVH
`define SRSC_REGS_SVH
`define SRSC_FETCH_RESET_ADDR 16'h0000
`define SRSC_RAM_WORDS        512
`define SRSC_RAM_AW           9
`define SRSC_RELEASE_CYCLES   4'h2
`define SRSC_SEQ_W            2
`define SRSC_RC_RESET         1'h1
`define SRSC_XTAL_RESET       1'h0
`define SRSC_DIV_RESET        3'h0
`define SRSC_CTRL_RESET       1'h0
`endif

// file: hw/srsc_top.sv
// start-up and reset state control: reset tree, cold-kept controls, clock setup
`timescale 1ns/100ps
`include "srsc_regs.svh"
module srsc_top #(
    parameter int RAM_WORDS = `SRSC_RAM_WORDS,
    parameter int RAM_AW    = `SRSC_RAM_AW
) (
    // clock and power-on reset
    input  wire logic              mclk,
    input  wire logic              reset,            // power-on reset, async high
    // merged reset requests and the sleep wake path
    input  wire logic              other_reset_req,  // enabled non-por sources, merged
    input  wire logic              porta_wake,       // leaving sleep via port-a combination
    // writes of the cold-governed system controls
    input  wire logic              ctrl_we,          // write of cold-governed controls
    input  wire logic              ctrl_port_config_reset_enable,
    input  wire logic              ctrl_sleep_enable,
    // writes of the clock configuration
    input  wire logic              clk_we,           // write of clock configuration
    input  wire logic              clk_rc_enable,
    input  wire logic              clk_xtal_enable,
    input  wire logic [2:0]        clk_cpu_div,
    // data ram port, never touched by any reset
    input  wire logic              ram_we,
    input  wire logic [RAM_AW-1:0] ram_addr,
    input  wire logic [7:0]        ram_wdata,
    output logic      [7:0]        ram_rdata,
    // reset tree, all registered
    output logic                   reset_cold_q,
    output logic                   reset_system_q,
    output logic                   reset_pconf_q,
    output logic                   cpu_reset_q,
    output logic      [15:0]       cpu_fetch_addr_q,
    // cold-governed controls, kept through a port-a wake
    output logic                   port_config_reset_enable_q,
    output logic                   sleep_enable_q,
    // clock configuration, sources kept through a system reset
    output logic                   rc_enable_q,
    output logic                   xtal_enable_q,
    output logic      [2:0]        cpu_clk_div_q
);
    // the tree runs in three stages: cold, then system only, then run;
    // the cold and system stages each hold for a fixed count so that every block sees its
    // reset for a few edges even when the cause was a one-cycle blip

    // the ram is built for exactly this depth; anything else is refused
    if (RAM_WORDS != `SRSC_RAM_WORDS) begin : g_bad_depth
        $error("srsc_top: ram depth must be 512");
    end
    // the address must reach every word
    if ((1 << RAM_AW) < RAM_WORDS) begin : g_bad_aw
        $error("srsc_top: ram address too narrow");
    end

    // release sequencer state
    srsc_pkg::srsc_state_t state_q;  // current release stage
    srsc_pkg::srsc_state_t state_d;  // next release stage
    logic [3:0]            cnt_q;    // hold counter within a stage
    logic [3:0]            cnt_d;    // next hold count
    logic                  cold_d;   // next cold reset level
    logic                  sys_d;    // next system reset level
    logic                  pconf_d;  // next port-config reset level
    logic                  cpu_d;    // next processor reset level
    logic [15:0]           fetch_d;  // next fetch address, always the restart one

    // true once a stage has held its reset for the full count
    function automatic logic hold_done(logic [3:0] cnt);
        return cnt == `SRSC_RELEASE_CYCLES;
    endfunction

    // sequencer next state: cold first, then system, then run
    // the cold stage ignores other sources: they cannot shorten it
    always_comb begin
        // default: stay in the stage and keep the count
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            srsc_pkg::SRSC_ST_COLD: begin
                // count out the cold hold, then drop to system only
                if (hold_done(cnt_q)) begin
                    state_d = srsc_pkg::SRSC_ST_SYS;
                    cnt_d   = 4'h0;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
            srsc_pkg::SRSC_ST_SYS: begin
                // the hold only starts once every source has gone quiet
                if (other_reset_req) begin
                    cnt_d = 4'h0;  // hold while a source stays active
                end else if (hold_done(cnt_q)) begin
                    state_d = srsc_pkg::SRSC_ST_RUN;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
            srsc_pkg::SRSC_ST_RUN: begin
                // any enabled source sends the tree back to system reset
                if (other_reset_req) begin
                    state_d = srsc_pkg::SRSC_ST_SYS;
                    cnt_d   = 4'h0;
                end
            end
            default: begin
                state_d = srsc_pkg::SRSC_ST_COLD;  // illegal code falls back to cold
                cnt_d   = 4'h0;
            end
        endcase
        // outputs decoded from next state so they leave on one common edge
        // decoding the current state instead would let each output lag
        // its stage by one edge, which a block watching two of them would see
        cold_d  = (state_d == srsc_pkg::SRSC_ST_COLD);
        sys_d   = (state_d != srsc_pkg::SRSC_ST_RUN);
        pconf_d = sys_d && (cold_d || port_config_reset_enable_q);
        cpu_d   = sys_d;
        // the processor always restarts from the fixed reset address
        fetch_d = `SRSC_FETCH_RESET_ADDR;
    end

    // sequencer registers; assertion is async, release is clocked
    // async assertion covers a clock that is not yet running at power-on;
    // clocked release keeps every reset-governed bit on one edge
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            // every output jumps at once, no clock needed
            state_q          <= srsc_pkg::SRSC_ST_COLD;
            cnt_q            <= 4'h0;
            reset_cold_q     <= 1'b1;
            reset_system_q   <= 1'b1;
            reset_pconf_q    <= 1'b1;
            cpu_reset_q      <= 1'b1;
            cpu_fetch_addr_q <= `SRSC_FETCH_RESET_ADDR;
        end else begin
            // release: the tree follows the stage decoded above
            state_q          <= state_d;
            cnt_q            <= cnt_d;
            reset_cold_q     <= cold_d;
            reset_system_q   <= sys_d;
            reset_pconf_q    <= pconf_d;
            cpu_reset_q      <= cpu_d;
            cpu_fetch_addr_q <= fetch_d;
        end
    end

    // cold-governed controls: cleared only by power-on reset
    // a system reset leaves them alone, which is what lets the port
    // configuration survive when its own reset is not enabled
    logic pcen_d;  // next port-config reset enable
    logic slen_d;  // next sleep enable
    always_comb begin
        // default: hold both controls
        pcen_d = port_config_reset_enable_q;
        slen_d = sleep_enable_q;
        // a port-a wake leaves these alone even if a write coincides
        if (ctrl_we && !porta_wake && !reset_system_q) begin
            pcen_d = ctrl_port_config_reset_enable;
            slen_d = ctrl_sleep_enable;
        end
    end

    // registers only; power-on clears them, nothing else does
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            port_config_reset_enable_q <= `SRSC_CTRL_RESET;
            sleep_enable_q             <= `SRSC_CTRL_RESET;
        end else begin
            port_config_reset_enable_q <= pcen_d;
            sleep_enable_q             <= slen_d;
        end
    end

    // clock setup: system reset only reinitialises the processor clock divider
    // the oscillators must not stop under a system reset, or the reset
    // itself could never be counted out; only the cpu divider falls back
    logic       rc_d;   // next rc oscillator enable
    logic       xt_d;   // next crystal oscillator enable
    logic [2:0] div_d;  // next processor clock divider
    always_comb begin
        // default: hold every field
        rc_d  = rc_enable_q;
        xt_d  = xtal_enable_q;
        div_d = cpu_clk_div_q;
        // writes are refused while the tree is still in system reset
        if (reset_system_q) begin
            div_d = `SRSC_DIV_RESET;
        end else if (clk_we) begin
            rc_d  = clk_rc_enable;
            xt_d  = clk_xtal_enable;
            div_d = clk_cpu_div;
        end
        // sources stay as they were through a system reset
    end

    // power-on brings up the rc oscillator with the crystal off, so the
    // first instructions always run on the rc clock; software may start
    // the crystal later and must wait for it before switching over
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rc_enable_q   <= `SRSC_RC_RESET;
            xtal_enable_q <= `SRSC_XTAL_RESET;
            cpu_clk_div_q <= `SRSC_DIV_RESET;
        end else begin
            rc_enable_q   <= rc_d;
            xtal_enable_q <= xt_d;
            cpu_clk_div_q <= div_d;
        end
    end

    // data ram keeps its contents across every reset
    // it has no reset pin at all, so its contents are unknown after power-on
    // and software must fill every word before reading it
    srsc_ram #(
        .WORDS (RAM_WORDS),
        .AW    (RAM_AW)
    ) u_ram (
        .mclk  (mclk),
        .we    (ram_we),
        .addr  (ram_addr),
        .wdata (ram_wdata),
        .rdata (ram_rdata)
    );
endmodule

// file: verif/srsc_top_sva.sv
// concurrent checks on the ports of the reset state control top
`timescale 1ns/100ps
module srsc_chk (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        other_reset_req,
    input wire logic        porta_wake,
    input wire logic        reset_cold_q,
    input wire logic        reset_system_q,
    input wire logic        reset_pconf_q,
    input wire logic        cpu_reset_q,
    input wire logic [15:0] cpu_fetch_addr_q,
    input wire logic        port_config_reset_enable_q,
    input wire logic        sleep_enable_q,
    input wire logic        rc_enable_q,
    input wire logic        xtal_enable_q,
    input wire logic [2:0]  cpu_clk_div_q
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    // system reset outlives its cause by at least two edges
    sequence s_sys_held;
        reset_system_q [*2];
    endsequence
    a_por_state: assert property (disable iff (1'b0)
        reset |-> reset_cold_q && reset_system_q && cpu_reset_q && rc_enable_q
        && !xtal_enable_q && !port_config_reset_enable_q && cpu_fetch_addr_q == 16'h0000)
        else $error("power-on state wrong");
    a_cold_sys: assert property (reset_cold_q |-> reset_system_q)
        else $error("cold without system reset");
    a_req_sys: assert property (other_reset_req |=> reset_system_q && cpu_reset_q)
        else $error("reset request ignored");
    a_req_release: assert property ($fell(other_reset_req) && !reset_cold_q
        |-> s_sys_held ##[1:3] (!reset_system_q && !cpu_reset_q))
        else $error("system reset release wrong");
    a_cold_release: assert property ($fell(reset_cold_q) |-> s_sys_held)
        else $error("system reset left with cold");
    a_pconf_gate: assert property ($rose(reset_system_q)
        |-> reset_pconf_q == $past(port_config_reset_enable_q))
        else $error("port config reset gating wrong");
    a_pconf_sys: assert property (reset_pconf_q |-> reset_system_q)
        else $error("port config reset alone");
    // the divider falls back one edge after system reset rises
    a_clk_kept: assert property ($rose(reset_system_q) |=> cpu_clk_div_q == 3'h0
        && $stable(rc_enable_q) && $stable(xtal_enable_q))
        else $error("clock setup disturbed");
    a_cold_kept: assert property ((reset_system_q || porta_wake) && !reset_cold_q
        |=> $stable(port_config_reset_enable_q) && $stable(sleep_enable_q))
        else $error("cold bits changed");
    a_fetch_zero: assert property (cpu_reset_q |-> cpu_fetch_addr_q == 16'h0000)
        else $error("fetch address not zero");
endmodule
bind srsc_top srsc_chk i_srsc_chk (.*);

// file: verif/test_srsc_top.sv
// self-checking bench for the reset state control top
`timescale 1ns/100ps
module test_srsc_top;
    logic        mclk, reset, other_reset_req, porta_wake, ctrl_we, clk_we, ram_we;
    logic        ctrl_port_config_reset_enable, ctrl_sleep_enable, clk_rc_enable;
    logic        clk_xtal_enable, reset_cold_q, reset_system_q, reset_pconf_q, cpu_reset_q;
    logic        port_config_reset_enable_q, sleep_enable_q, rc_enable_q, xtal_enable_q;
    logic [2:0]  clk_cpu_div, cpu_clk_div_q;
    logic [8:0]  ram_addr;
    logic [7:0]  ram_wdata, ram_rdata;
    logic [15:0] cpu_fetch_addr_q;
    int          fails, num_checks;
    logic [4:0]  rows [4] = '{5'h00, 5'h1F, 5'h0D, 5'h12}; // rc, xtal, cpu divider
    srsc_top i_srsc_top (.*);
    // packed view: rc xtal cold sys cpu pconf pcre sleep, then divider
    function automatic logic [15:0] st();
        return {rc_enable_q, xtal_enable_q, reset_cold_q, reset_system_q, cpu_reset_q,
                reset_pconf_q, port_config_reset_enable_q, sleep_enable_q, 5'h00, cpu_clk_div_q};
    endfunction
    task automatic check(logic [15:0] got, logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // inputs always move 1 ns after the rising edge
    task automatic tick(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // bounded wait for the system reset to let go
    task automatic wait_run;
        int i;
        for (i = 0; i < 50 && reset_system_q !== 1'b0; i++) tick(1);
        if (i == 50) begin
            fails++;
            finish_test;
        end
    endtask
    task automatic wr_clk(logic [4:0] v);
        {clk_rc_enable, clk_xtal_enable, clk_cpu_div} = v;
        clk_we = 1'b1;
        tick(1);
        clk_we = 1'b0;
        // one idle edge so a following call never re-raises the strobe at once
        tick(1);
    endtask
    task automatic wr_ctrl(logic [1:0] v);
        {ctrl_port_config_reset_enable, ctrl_sleep_enable} = v;
        ctrl_we = 1'b1;
        tick(1);
        ctrl_we = 1'b0;
        tick(1);
    endtask
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        {reset, other_reset_req, porta_wake, ctrl_we, clk_we, ram_we} = 6'h00;
        {ctrl_port_config_reset_enable, ctrl_sleep_enable, clk_rc_enable} = 3'h0;
        {clk_xtal_enable, clk_cpu_div, ram_addr, ram_wdata} = 21'h000000;
        fails = 0;
        num_checks = 0;
        // raise reset just after time zero so its edge reaches every flop that has a reset
        #1;
        reset = 1'b1;
        tick(20);
        check(st(), 16'hBC00);
        check(cpu_fetch_addr_q, 16'h0000);
        reset = 1'b0;
        wait_run;
        check(st(), 16'h8000);
        {ram_we, ram_addr, ram_wdata} = 18'h3FFA5;
        tick(1);
        ram_we = 1'b0;
        foreach (rows[i]) begin
            wr_clk(rows[i]);
            check(st(), {rows[i][4:3], 11'h000, rows[i][2:0]});
        end
        wr_ctrl(2'h3);
        other_reset_req = 1'b1;
        tick(2);
        check(st(), 16'h9F00);
        wr_clk(5'h00);
        wr_ctrl(2'h0);
        check(st(), 16'h9F00);
        check(cpu_fetch_addr_q, 16'h0000);
        other_reset_req = 1'b0;
        wait_run;
        check(st(), 16'h8300);
        wr_ctrl(2'h1);
        other_reset_req = 1'b1;
        tick(2);
        check(st(), 16'h9900);
        other_reset_req = 1'b0;
        wait_run;
        porta_wake = 1'b1;
        wr_ctrl(2'h2);
        porta_wake = 1'b0;
        check(st(), 16'h8100);
        wr_clk(5'h0F);
        reset = 1'b1;
        tick(2);
        check(st(), 16'hBC00);
        reset = 1'b0;
        wait_run;
        check(st(), 16'h8000);
        check({8'h00, ram_rdata}, 16'h00A5);
        finish_test;
    end
endmodule
